// ### core/ac_source_setting_ctrl.v
// Setting and output-state controller with an AHB-Lite register slave
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`default_nettype none
`include "ac_src_consts.vh"

module ac_source_setting_ctrl (
   input wire ref_clk,
   input wire srst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg hreadyout,
   output reg [31:0] hrdata,
   output reg hresp,
   input wire [3:0] nv_range,
   input wire [3:0] nv_den,
   input wire overload,
   input wire [15:0] meas_val,
   output reg [3:0] range_sel,
   output reg [3:0] den_sel,
   output reg volt_drive,
   output reg curr_drive,
   output reg lamp_on,
   output reg lamp_off,
   output reg hv_lamp,
   output reg beep,
   output reg [7:0] err_code,
   output reg [17:0] out_level,
   output reg [15:0] display
);

   // Range rating in resolution counts
   function [13:0] rating;
      input [3:0] rc;
      begin
         case (rc)
            `RC_V300: rating = `RAT_V300;
            `RC_A50: rating = `RAT_A50;
            default: rating = `RAT_STD;
         endcase
      end
   endfunction

   // Upper limit, 120 % of the rating
   function [15:0] lvl_max;
      input [3:0] rc;
      reg [13:0] r;
      begin
         r = rating(rc);
         lvl_max = {2'h0, r} + {2'h0, r / 14'h0005};
      end
   endfunction

   // Only six voltage and four current codes are legal
   function rc_valid;
      input [3:0] rc;
      begin
         if (rc[`RC_CUR_BIT])
            rc_valid = (rc[2:0] <= `RC_AMAX);
         else
            rc_valid = (rc[2:0] <= `RC_VMAX);
      end
   endfunction

   // Weight of the dial digit
   function [15:0] weight;
      input [2:0] pos;
      begin
         case (pos)
            3'h0: weight = `W0;
            3'h1: weight = `W1;
            3'h2: weight = `W2;
            3'h3: weight = `W3;
            default: weight = `W4;
         endcase
      end
   endfunction

   reg [3:0] range_q;
   reg [3:0] range_d;
   reg [15:0] lvl_q;
   reg [15:0] lvl_d;
   reg [3:0] den_q;
   reg [3:0] den_d;
   reg [3:0] num_q;
   reg [3:0] num_d;
   reg out_en_q;
   reg out_en_d;
   reg err_q;
   reg err_d;
   reg beep_en_q;
   reg beep_en_d;
   reg lvl_upd;
   reg [7:0] addr_q;
   reg wr_q;
   reg ovl_s1_q;
   reg ovl_s2_q;
   reg [15:0] meas_s1_q;
   reg [15:0] meas_s2_q;
   reg [15:0] step_sum;
   reg [15:0] step_w;
   reg [29:0] resc_prod;
   reg [29:0] resc_div;
   reg [31:0] rd_mux;
   reg [15:0] lvl_lim;
   reg [16:0] step_up;
   reg hv_rng;
   reg beep_rng;
   reg rng_new;
   reg [3:0] nvr_s1_q;
   reg [3:0] nvr_s2_q;
   reg [3:0] nvd_s1_q;
   reg [3:0] nvd_s2_q;

   wire addr_ok = (haddr[31:8] == 24'h000000);
   wire take = hsel & htrans[1] & hready;
   wire wr_take = wr_q;

   // Bus address phase capture; zero wait states
   always @(posedge ref_clk) begin
      if (srst) begin
         addr_q <= 8'h00;
         wr_q <= 1'b0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_q <= take & hwrite & addr_ok;
         addr_q <= haddr[7:0];
         if (take & ~hwrite)
            hrdata <= addr_ok ? rd_mux : 32'h00000000;
      end
   end

   // Read mux; unmapped words read as zero
   always @* begin
      rd_mux = 32'h00000000;
      case (haddr[7:0])
         `RA_RANGE: rd_mux = {28'h0000000, range_q};
         `RA_LEVEL: rd_mux = {16'h0000, lvl_q};
         `RA_DEN: rd_mux = {28'h0000000, den_q};
         `RA_NUM: rd_mux = {28'h0000000, num_q};
         `RA_OUTPUT: rd_mux = {31'h00000000, out_en_q};
         `RA_STATUS: rd_mux = {30'h00000000, err_q, out_en_q};
         `RA_CTRL: rd_mux = {31'h00000000, beep_en_q};
         `RA_OUTLVL: rd_mux = {14'h0000, out_level};
         `RA_MEAS: rd_mux = {16'h0000, meas_s2_q};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Pin inputs pass two flops before use
   always @(posedge ref_clk) begin
      if (srst) begin
         ovl_s1_q <= 1'b0;
         ovl_s2_q <= 1'b0;
         meas_s1_q <= 16'h0000;
         meas_s2_q <= 16'h0000;
      end else begin
         ovl_s1_q <= overload;
         ovl_s2_q <= ovl_s1_q;
         meas_s1_q <= meas_val;
         meas_s2_q <= meas_s1_q;
      end
   end

   // Retained codes pass two flops; reset must span three edges so
   // that the restored range and denominator have settled
   always @(posedge ref_clk) begin
      nvr_s1_q <= nv_range;
      nvr_s2_q <= nvr_s1_q;
      nvd_s1_q <= nv_den;
      nvd_s2_q <= nvd_s1_q;
   end

   // Ranges able to reach high voltage; lamp and beep share it
   always @* begin
      hv_rng = (range_q == `RC_V300) || (range_q == `RC_V1000);
      beep_rng = (range_d == `RC_V300) || (range_d == `RC_V1000);
   end

   // A legal range code that differs from the held one
   always @* begin
      rng_new = rc_valid(hwdata[3:0]) && (hwdata[3:0] != range_q);
   end

   // Rescale and dial step arithmetic
   always @* begin
      lvl_lim = lvl_max(range_q);
      resc_prod = {14'h0000, lvl_q} * {16'h0000, rating(hwdata[3:0])};
      resc_div = resc_prod / {16'h0000, rating(range_q)};
      step_w = weight(hwdata[2:0]);
      // One bit wider so a large digit cannot wrap past the limit
      step_up = {1'b0, lvl_q} + {1'b0, step_w};
      if (hwdata[`F_STEP_DN]) begin
         // Borrow saturates at zero
         if (lvl_q < step_w)
            step_sum = 16'h0000;
         else
            step_sum = lvl_q - step_w;
      end else begin
         // Carry saturates at the upper limit
         if (step_up > {1'b0, lvl_lim})
            step_sum = lvl_lim;
         else
            step_sum = step_up[15:0];
      end
   end

   // Next-state of the settings and output state
   always @* begin
      range_d = range_q;
      lvl_d = lvl_q;
      den_d = den_q;
      num_d = num_q;
      out_en_d = out_en_q;
      err_d = err_q;
      beep_en_d = beep_en_q;
      lvl_upd = 1'b0;
      if (wr_take) begin
         case (addr_q)
            `RA_RANGE: begin
               // Only software moves the range; no auto ranging
               if (rng_new) begin
                  range_d = hwdata[3:0];
                  lvl_d = resc_div[15:0];
                  lvl_upd = 1'b1;
                  out_en_d = 1'b0;
               end
            end
            `RA_LEVEL: begin
               // Output state is left alone here
               if (hwdata[15:0] > lvl_max(range_q))
                  lvl_d = lvl_max(range_q);
               else
                  lvl_d = hwdata[15:0];
               lvl_upd = 1'b1;
            end
            `RA_STEP: begin
               lvl_d = step_sum;
               lvl_upd = 1'b1;
            end
            `RA_DEN: begin
               if (hwdata[3:0] >= `DEN_MIN) begin
                  den_d = hwdata[3:0];
                  num_d = hwdata[3:0];
               end
            end
            `RA_NUM: begin
               // Values above the denominator are refused
               if (hwdata[31:4] == 28'h0000000 &&
                   hwdata[`F_NUM_MSB:0] <= den_q)
                  num_d = hwdata[`F_NUM_MSB:0];
            end
            `RA_OUTPUT: begin
               if (hwdata[`F_OUT_TOG])
                  out_en_d = ~out_en_q;
            end
            `RA_STATUS: begin
               if (hwdata[`F_ST_ERRCLR])
                  err_d = 1'b0;
            end
            `RA_CTRL: beep_en_d = hwdata[`F_CTRL_BEEP];
            default: begin
            end
         endcase
      end
      // With the output on, overload wins over a toggle and over the error clear
      if (ovl_s2_q && out_en_q) begin
         out_en_d = 1'b0;
         err_d = 1'b1;
      end
   end

   // Setting state; reset restores retained range and denominator
   always @(posedge ref_clk) begin
      if (srst) begin
         if (rc_valid(nvr_s2_q))
            range_q <= nvr_s2_q;
         else
            range_q <= `RC_DEFAULT;
         if (nvd_s2_q >= `DEN_MIN) begin
            den_q <= nvd_s2_q;
            num_q <= nvd_s2_q;
         end else begin
            den_q <= `DEN_DEFAULT;
            num_q <= `DEN_DEFAULT;
         end
         lvl_q <= `LVL_RST;
         out_en_q <= 1'b0;
         err_q <= 1'b0;
         beep_en_q <= `CTRL_RST;
      end else begin
         range_q <= range_d;
         lvl_q <= lvl_d;
         den_q <= den_d;
         num_q <= num_d;
         out_en_q <= out_en_d;
         err_q <= err_d;
         beep_en_q <= beep_en_d;
      end
   end

   // Output-facing flops; one cycle behind the settings, except beep, set on the edge the level updates
   always @(posedge ref_clk) begin
      if (srst) begin
         range_sel <= `RC_DEFAULT;
         den_sel <= `DEN_DEFAULT;
         volt_drive <= 1'b0;
         curr_drive <= 1'b0;
         lamp_on <= 1'b0;
         lamp_off <= 1'b1;
         hv_lamp <= 1'b0;
         beep <= 1'b0;
         err_code <= `ERR_NONE;
         out_level <= 18'h00000;
         display <= 16'h0000;
      end else begin
         range_sel <= range_q;
         den_sel <= den_q;
         volt_drive <= out_en_q & ~range_q[`RC_CUR_BIT];
         curr_drive <= out_en_q & range_q[`RC_CUR_BIT];
         lamp_on <= out_en_q;
         lamp_off <= ~out_en_q;
         // Lit even with the output off
         hv_lamp <= hv_rng;
         // Only the 300 V and 1000 V ranges can reach 150 V
         beep <= lvl_upd & beep_en_q & beep_rng &
                 (lvl_d >= `BEEP_LVL);
         err_code <= err_q ? `ERR_OVL : `ERR_NONE;
         // Headroom bits leave room for deviation up to 144 %
         out_level <= ({2'h0, lvl_q} * {14'h0000, num_q}) /
                      {14'h0000, den_q};
         display <= out_en_q ? meas_s2_q : 16'h0000;
      end
   end

endmodule // ac_source_setting_ctrl
`default_nettype wire

// ### core/ac_src_consts.vh
// Constants for the AC source setting and output-state controller
`ifndef AC_SRC_CONSTS_VH
`define AC_SRC_CONSTS_VH

// Register byte offsets on the bus
`define RA_RANGE 8'h00
`define RA_LEVEL 8'h04
`define RA_STEP 8'h08
`define RA_DEN 8'h0c
`define RA_NUM 8'h10
`define RA_OUTPUT 8'h14
`define RA_STATUS 8'h18
`define RA_CTRL 8'h1c
`define RA_OUTLVL 8'h20
`define RA_MEAS 8'h24

// Range code {current_sel, index[2:0]}
`define RC_CUR_BIT 3
`define RC_V100M 4'h0
`define RC_V1 4'h1
`define RC_V300 4'h4
`define RC_V1000 4'h5
`define RC_A50 4'hb
`define RC_VMAX 3'h5
`define RC_AMAX 3'h3
`define RC_DEFAULT 4'h1

// Range rating in counts of resolution (100 %)
`define RAT_STD 14'h2710
`define RAT_V300 14'h0bb8
`define RAT_A50 14'h1388
// Beep threshold: 150.0 V in 0.1 V counts
`define BEEP_LVL 16'h05dc

// Digit weights for dial steps
`define W0 16'h0001
`define W1 16'h000a
`define W2 16'h0064
`define W3 16'h03e8
`define W4 16'h2710

// Divider limits
`define DEN_MIN 4'h4
`define DEN_MAX 4'hf
`define DEN_DEFAULT 4'ha

// Field positions
`define F_NUM_MSB 3
`define F_STEP_DN 8
`define F_OUT_TOG 0
`define F_ST_ERRCLR 1
`define F_CTRL_BEEP 0

// Error code for overload
`define ERR_OVL 8'h01
`define ERR_NONE 8'h00

// Reset values
`define LVL_RST 16'h0000
`define CTRL_RST 1'b1

`endif

// ### bench/ac_src_asserts.sv
// Checker of output-state and setting rules for the source controller
`default_nettype none
`include "ac_src_consts.vh"
module ac_src_asserts (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [3:0] range_sel,
   input wire logic [3:0] den_sel,
   input wire logic volt_drive,
   input wire logic curr_drive,
   input wire logic lamp_on,
   input wire logic lamp_off,
   input wire logic hv_lamp,
   input wire logic beep,
   input wire logic overload,
   input wire logic [7:0] err_code
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   // Range held two edges, so pins that lag a cycle have caught up
   sequence s_rng_still;
      $stable(range_sel) [*2];
   endsequence
   // Overload arriving while the output is on
   sequence s_ovl_on;
      $rose(overload) && lamp_on;
   endsequence
   a_lamp_pair: assert property (lamp_on != lamp_off)
      else $error("on and off lamps agree");
   a_hv_range: assert property (s_rng_still |-> hv_lamp ==
      (range_sel == `RC_V300 || range_sel == `RC_V1000))
      else $error("hv lamp wrong for range");
   a_drive_route: assert property (s_rng_still |->
      volt_drive == (lamp_on && !range_sel[3]) &&
      curr_drive == (lamp_on && range_sel[3]))
      else $error("terminal drive wrong");
   a_range_off: assert property ($changed(range_sel) |-> !lamp_on)
      else $error("output kept on across range change");
   a_den_limits: assert property (den_sel >= `DEN_MIN)
      else $error("denominator below limit");
   a_beep_pulse: assert property (beep |=> !beep)
      else $error("beep longer than one cycle");
   a_ovl_off: assert property (s_ovl_on |-> ##[1:6] !lamp_on)
      else $error("overload left output on");
   a_err_off: assert property (err_code != `ERR_NONE |->
      err_code == `ERR_OVL && !lamp_on)
      else $error("error code with output on");
endmodule // ac_src_asserts
bind ac_source_setting_ctrl ac_src_asserts u_chk (.ref_clk(ref_clk),
   .srst(srst), .range_sel(range_sel), .den_sel(den_sel),
   .volt_drive(volt_drive), .curr_drive(curr_drive), .lamp_on(lamp_on),
   .lamp_off(lamp_off), .hv_lamp(hv_lamp), .beep(beep),
   .overload(overload), .err_code(err_code));
`default_nettype wire

// ### bench/analog_side.sv
// Model of retained storage, load and measurement stage
`default_nettype none
module analog_side #(
   parameter logic [3:0] INIT_RANGE = 4'h2,
   parameter logic [3:0] INIT_DEN = 4'h6
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic fault,
   input wire logic [3:0] range_sel,
   input wire logic [3:0] den_sel,
   input wire logic volt_drive,
   input wire logic curr_drive,
   input wire logic [17:0] out_level,
   output logic [3:0] nv_range,
   output logic [3:0] nv_den,
   output logic overload,
   output logic [15:0] meas_val
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] keep_rng = INIT_RANGE;
   logic [3:0] keep_den = INIT_DEN;
   logic drv;
   logic srst_q = 1'b1;
   // Frozen in reset and one edge after, while the pins show defaults
   always @(posedge ref_clk) begin
      srst_q <= srst;
      if (!srst && !srst_q) begin
         keep_rng <= range_sel;
         keep_den <= den_sel;
      end
   end
   // A faulty load only overloads driven terminals; idle reads zero
   assign drv = volt_drive || curr_drive;
   assign nv_range = keep_rng;
   assign nv_den = keep_den;
   assign overload = fault && drv;
   assign meas_val = drv ? out_level[15:0] : 16'h0000;
endmodule // analog_side
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the source setting controller
`default_nettype none
`include "ac_src_consts.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, srst, hsel, hwrite, fault, hready, hreadyout, hresp;
   logic volt_drive, curr_drive, lamp_on, lamp_off, hv_lamp, beep, overload;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] nv_range, nv_den, range_sel, den_sel;
   logic [7:0] err_code;
   logic [17:0] out_level;
   logic [15:0] meas_val, display;
   int fail_count, checks, beeps, lvl, den, num, rc, w, mx;
   assign hready = hreadyout;
   ac_source_setting_ctrl DUT (.ref_clk(ref_clk), .srst(srst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .nv_range(nv_range), .nv_den(nv_den), .overload(overload),
      .meas_val(meas_val), .range_sel(range_sel), .den_sel(den_sel),
      .volt_drive(volt_drive), .curr_drive(curr_drive), .lamp_on(lamp_on),
      .lamp_off(lamp_off), .hv_lamp(hv_lamp), .beep(beep),
      .err_code(err_code), .out_level(out_level), .display(display));
   analog_side u_side (.ref_clk(ref_clk), .srst(srst), .fault(fault),
      .range_sel(range_sel), .den_sel(den_sel), .volt_drive(volt_drive),
      .curr_drive(curr_drive), .out_level(out_level), .nv_range(nv_range),
      .nv_den(nv_den), .overload(overload), .meas_val(meas_val));
   // Free-running 25 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // Beep pulses counted as they occur
   always @(posedge ref_clk) begin
      if (beep === 1'b1) beeps++;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Bounded wait for hready; a hang ends the run
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      if (hready !== 1'b1) begin
         fail_count++;
         summarize();
      end
   endtask
   task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic rd_chk(string what, logic [7:0] a, logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(what, exp, rd);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic do_reset();
      srst <= 1'b1;
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk("range", 32'(nv_range), {28'h0, range_sel});
      chk("den", 32'(nv_den), {28'h0, den_sel});
      rd_chk("num", `RA_NUM, 32'(nv_den));
      $display("test reset restore done");
   endtask
   function automatic int lmax(int c);
      return 6 * ((c == 4) ? 3000 : (c == 11) ? 5000 : 10000) / 5;
   endfunction
   initial begin
      {hsel, hwrite, fault} = 3'h0;
      srst = 1'b1;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'b00;
      hsize = 3'h2;
      lvl = $urandom(54);
      do_reset();
      // Every denominator value; zero numerator shows the forced reload
      for (int d = 0; d < 16; d++) begin
         bus(1'b1, `RA_NUM, 32'h0);
         bus(1'b1, `RA_DEN, d);
         den = (d >= 4) ? d : 6;
         rd_chk("den", `RA_DEN, den);
         rd_chk("num", `RA_NUM, (d >= 4) ? d : 0);
      end
      bus(1'b1, `RA_DEN, 9);
      {den, num} = {32'd9, 32'd9};
      for (int i = 0; i < 12; i++) begin
         lvl = (i == 0) ? den + 1 : $urandom_range(15);
         bus(1'b1, `RA_NUM, lvl);
         if (lvl <= den) num = lvl;
         rd_chk("num", `RA_NUM, num);
      end
      $display("test divider done");
      // All ten ranges; the 300 V pass probes one count over 360.0 V
      for (int i = 0; i < 10; i++) begin
         rc = (i < 6) ? i : i + 2;
         lvl = (i == 4) ? 3601 : $urandom_range(15000);
         bus(1'b1, `RA_RANGE, rc);
         bus(1'b1, `RA_LEVEL, lvl);
         if (lvl > lmax(rc)) lvl = lmax(rc);
         rd_chk("level", `RA_LEVEL, lvl);
         rd_chk("outlvl", `RA_OUTLVL, lvl * num / den);
         rd_chk("range", `RA_RANGE, rc);
         chk("hv", rc == 4 || rc == 5, {31'h0, hv_lamp});
      end
      $display("test ranges done");
      bus(1'b1, `RA_RANGE, `RC_V1);
      bus(1'b1, `RA_LEVEL, 5000);
      bus(1'b1, `RA_RANGE, 2);
      rd_chk("rescale", `RA_LEVEL, 5000);
      beeps = 0;
      bus(1'b1, `RA_RANGE, `RC_V300);
      rd_chk("rescale", `RA_LEVEL, 1500);
      chk("beep", 1, beeps);
      bus(1'b1, `RA_CTRL, 0);
      bus(1'b1, `RA_LEVEL, 2000);
      chk("muted", 1, beeps);
      $display("test rescale done");
      bus(1'b1, `RA_CTRL, 1);
      // Dial steps: ceiling, floor, then random carries and borrows
      lvl = 2000;
      for (int i = 0; i < 16; i++) begin
         rc = (i < 4) ? 4 + i : $urandom_range(7);
         w = (rc >= 4) ? 10000 : 10 ** rc;
         mx = (i < 2) ? 0 : (i < 4) ? 1 : $urandom_range(1);
         bus(1'b1, `RA_STEP, rc + (mx << 8));
         if (mx == 1) lvl = (lvl < w) ? 0 : lvl - w;
         else lvl = (lvl + w > 3600) ? 3600 : lvl + w;
         rd_chk("step", `RA_LEVEL, lvl);
      end
      $display("test steps done");
      bus(1'b1, `RA_RANGE, `RC_V1);
      bus(1'b1, `RA_OUTPUT, 1);
      rd_chk("on", `RA_STATUS, 1);
      chk("lamps", 2'b10, {lamp_on, lamp_off});
      chk("drive", 2'b10, {volt_drive, curr_drive});
      bus(1'b1, `RA_LEVEL, 1234);
      rd_chk("on", `RA_OUTPUT, 1);
      rd_chk("meas", `RA_MEAS, 1234 * num / den);
      chk("display", 1234 * num / den, {16'h0, display});
      bus(1'b1, `RA_RANGE, 4'h9);
      rd_chk("off", `RA_STATUS, 0);
      chk("lamps", 2'b01, {lamp_on, lamp_off});
      bus(1'b1, `RA_OUTPUT, 0);
      bus(1'b1, `RA_OUTPUT, 1);
      rd_chk("on", `RA_STATUS, 1);
      chk("drive", 2'b01, {volt_drive, curr_drive});
      fault <= 1'b1;
      repeat (8) @(posedge ref_clk);
      rd_chk("trip", `RA_STATUS, 2);
      chk("err", `ERR_OVL, err_code);
      fault <= 1'b0;
      bus(1'b1, `RA_STATUS, 2);
      rd_chk("clear", `RA_STATUS, 0);
      $display("test output done");
      bus(1'b1, `RA_RANGE, 4'h6);
      bus(1'b1, `RA_RANGE, 4'hc);
      rd_chk("range", `RA_RANGE, 9);
      rd_chk("hole", 8'h80, 0);
      do_reset();
      summarize();
   end
endmodule // tb
`default_nettype wire
